// >>> hw/ms_timer.sv
// Millisecond counter with saturating done flag, restarted by clear
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
  parameter logic [5:0] LIMIT = 6'd16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic clear,
  input  wire logic tick,
  output var  logic done
);
  logic [5:0] cnt_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 6'h00;
    end else if (clear) begin
      cnt_ff <= 6'h00;
    end else if (tick && cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  assign done = (cnt_ff == LIMIT);
endmodule : ms_timer
`default_nettype wire

// >>> hw/nt_act_map.svh
// Command and indication codes, timing counts and divider settings for the activation controller
`ifndef NT_ACT_MAP_SVH
`define NT_ACT_MAP_SVH

// Commands from upstream
`define CMD_DEACT_REQ      4'h0
`define CMD_STATE_RESET    4'h1
`define CMD_SINGLE_PULSE   4'h2
`define CMD_CONT_PULSE     4'h3
`define CMD_NOT_SYNC       4'h4
`define CMD_ACT_REQ        4'h8
`define CMD_ACT_LOOP       4'ha
`define CMD_SWITCH_THRU    4'hc
`define CMD_LOOP_SWITCH    4'he
`define CMD_DEACT_CONFIRM  4'hf

// Indications to upstream
`define IND_TIMING         4'h0
`define IND_NOT_SYNC       4'h4
`define IND_ACT_REQ        4'h8
`define IND_CODE_VIOL      4'hb
`define IND_ACT            4'hc
`define IND_DEACT          4'hf

// Transmit info selection
`define TX_INFO0           3'h0
`define TX_INFO2           3'h1
`define TX_INFO4           3'h2
`define TX_SINGLE_PULSE    3'h3
`define TX_CONT_PULSE      3'h4

// Timing: 100 MHz clock, 1 ms tick from a divider
`define CLK_PERIOD_NS      10
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define INFO0_HOLD_MS      16
`define DEACT_TIMEOUT_MS   32

`endif

// >>> hw/nt_act_pkg.sv
// Types for the network-termination activation controller
`default_nettype none
package nt_act_pkg;

  typedef enum logic [11:0] {
    ST_DEACTIVATED  = 12'h001,
    ST_INFO0_SEEN   = 12'h002,
    ST_PEND_ACT     = 12'h004,
    ST_WAIT_SWITCH  = 12'h008,
    ST_ACTIVATED    = 12'h010,
    ST_LOST_LINE    = 12'h020,
    ST_LOST_UP      = 12'h040,
    ST_PEND_DEACT   = 12'h080,
    ST_WAIT_CONFIRM = 12'h100,
    ST_TEST_SINGLE  = 12'h200,
    ST_TEST_CONT    = 12'h400,
    ST_RESET_HOLD   = 12'h800
  } act_state_t;

endpackage : nt_act_pkg
`default_nettype wire

// >>> hw/nt_line_activation_fsm.sv
// Activation and deactivation state machine of the line transceiver in network-termination mode
//
// Behaviour
// - Deactivated sends nothing, freezes clocks if clock_freeze_sel, activates from line or bus
// - Info 0 seen while deactivated reports code 1000, then waits for activation command
// - Activation command enters pending activation, sends info 2 until info 3 arrives
// - Loop activation command 1010 during activation closes loop 2
// - After info 3, keep info 2 and wait for switch-through
// - Switch-through 1100 activates, sends info 4, channels made transparent
// - Loop switch-through 1110 while activated closes loop 2
// - Lost line sync while activated enters lost framing, reports 0100
// - Upstream not-synchronous command 0100 enters upstream lost framing, sends info 2
// - Deactivation request 0000 accepted in any state but pending deactivation and wait-for-confirm, sends info 0, pending deactivation
// - Report 1111 after 16 ms of info 0 or 32 ms timeout
// - Hold final state until confirm 1111, then deactivated with detection enabled
// - Reset command 0001 unconditional, sends info 0, ignores line while applied
// - Test commands 0010/0011 enter test from non-test states; never back to back
// - Code violation 1011 reported only when violation_report_en is set
// - Timing indication 0000 output during deactivation procedure
// - Indication is derived from current state and shown continuously
// - Receiver classes: info 0, level, info 3, other than info 3
`timescale 1ns/1ps
`default_nettype none
`include "nt_act_map.svh"
module nt_line_activation_fsm (
  // Clock and reset
  input  wire  logic       clk,
  input  wire  logic       reset,
  // Configuration levels
  input  wire  logic       clock_freeze_sel,
  input  wire  logic       violation_report_en,
  // Command field from upstream, same clock domain
  input  wire  logic [3:0] command_indicate_field,
  // Line receiver pins
  input  wire  logic       rx_info0_pin,
  input  wire  logic       rx_info3_pin,
  input  wire  logic       rx_sync_pin,
  input  wire  logic       rx_code_viol_pin,
  // Indication to upstream
  output var   logic [3:0] indication,
  // Line transmitter and status
  output var   logic [2:0] tx_info_sel,
  output var   logic       loop2_closed,
  output var   logic       channels_transparent,
  output var   logic       clock_stop,
  output var   logic       rx_ignore
);
  logic rx_info0_s;
  logic rx_info3_s;
  logic rx_sync_s;
  logic rx_cv_s;

  pin_sync u_sync_i0 (.clk(clk), .reset(reset), .pin_in(rx_info0_pin), .level_out(rx_info0_s));
  pin_sync u_sync_i3 (.clk(clk), .reset(reset), .pin_in(rx_info3_pin), .level_out(rx_info3_s));
  pin_sync u_sync_sy (.clk(clk), .reset(reset), .pin_in(rx_sync_pin), .level_out(rx_sync_s));
  pin_sync u_sync_cv (.clk(clk), .reset(reset), .pin_in(rx_code_viol_pin), .level_out(rx_cv_s));

  // Receiver classes, all masked while the reset command holds
  wire cmd_reset   = (command_indicate_field == `CMD_STATE_RESET);
  wire rx_i0       = rx_info0_s && !cmd_reset;
  wire rx_level    = !rx_info0_s && !cmd_reset;
  wire rx_i3       = rx_info3_s && !cmd_reset;
  wire rx_not_i3   = !rx_info3_s && !cmd_reset;
  wire rx_synced   = rx_sync_s && !cmd_reset;
  wire rx_cv       = rx_cv_s && !cmd_reset;

  // Command decode
  wire cmd_deact   = (command_indicate_field == `CMD_DEACT_REQ);
  wire cmd_single  = (command_indicate_field == `CMD_SINGLE_PULSE);
  wire cmd_cont    = (command_indicate_field == `CMD_CONT_PULSE);
  wire cmd_nsync   = (command_indicate_field == `CMD_NOT_SYNC);
  wire cmd_act     = (command_indicate_field == `CMD_ACT_REQ);
  wire cmd_actloop = (command_indicate_field == `CMD_ACT_LOOP);
  wire cmd_switch  = (command_indicate_field == `CMD_SWITCH_THRU);
  wire cmd_lswitch = (command_indicate_field == `CMD_LOOP_SWITCH);
  wire cmd_confirm = (command_indicate_field == `CMD_DEACT_CONFIRM);

  // Millisecond tick divider
  logic [16:0] div_ff;
  logic        tick_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_ff  <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 17'(`TICK_CYCLES - 1));
      div_ff  <= (div_ff == 17'(`TICK_CYCLES - 1)) ? 17'h00000 : div_ff + 17'h00001;
    end
  end

  nt_act_pkg::act_state_t state_ff;
  nt_act_pkg::act_state_t nxt_state;
  logic                   loop_ff;
  logic                   nxt_loop;

  // Deactivation supervision timers
  wire in_pdeact  = (state_ff == nt_act_pkg::ST_PEND_DEACT);
  wire i0_done;
  wire tmo_done;
  ms_timer #(.LIMIT(6'(`INFO0_HOLD_MS))) u_i0_timer (
    .clk(clk), .reset(reset), .clear(!in_pdeact || !rx_i0), .tick(tick_ff), .done(i0_done)
  );
  ms_timer #(.LIMIT(6'(`DEACT_TIMEOUT_MS))) u_tmo_timer (
    .clk(clk), .reset(reset), .clear(!in_pdeact), .tick(tick_ff), .done(tmo_done)
  );

  wire in_test = (state_ff == nt_act_pkg::ST_TEST_SINGLE) || (state_ff == nt_act_pkg::ST_TEST_CONT);
  // A request left on the field must not hold off the supervision timers
  wire deact_busy = in_pdeact || (state_ff == nt_act_pkg::ST_WAIT_CONFIRM);

  always_comb begin
    nxt_state = state_ff;
    nxt_loop  = loop_ff;
    if (cmd_reset) begin
      nxt_state = nt_act_pkg::ST_RESET_HOLD;
      nxt_loop  = 1'b0;
    end else if (cmd_deact && !deact_busy) begin
      nxt_state = nt_act_pkg::ST_PEND_DEACT;
      nxt_loop  = 1'b0;
    end else if (cmd_single && !in_test) begin
      nxt_state = nt_act_pkg::ST_TEST_SINGLE;
    end else if (cmd_cont && !in_test) begin
      nxt_state = nt_act_pkg::ST_TEST_CONT;
    end else begin
      unique case (state_ff)
        nt_act_pkg::ST_RESET_HOLD: begin
          nxt_state = nt_act_pkg::ST_DEACTIVATED;
        end
        nt_act_pkg::ST_DEACTIVATED: begin
          if (cmd_act || cmd_actloop) begin
            nxt_state = nt_act_pkg::ST_PEND_ACT;
            nxt_loop  = cmd_actloop;
          end else if (rx_i0) begin
            nxt_state = nt_act_pkg::ST_INFO0_SEEN;
          end
        end
        nt_act_pkg::ST_INFO0_SEEN: begin
          if (cmd_act || cmd_actloop) begin
            nxt_state = nt_act_pkg::ST_PEND_ACT;
            nxt_loop  = cmd_actloop;
          end else if (rx_level) begin
            // Info 0 no longer seen before upstream answered
            nxt_state = nt_act_pkg::ST_DEACTIVATED;
          end
        end
        nt_act_pkg::ST_PEND_ACT: begin
          if (cmd_actloop) begin
            nxt_loop = 1'b1;
          end
          if (rx_i3) begin
            nxt_state = nt_act_pkg::ST_WAIT_SWITCH;
          end
        end
        nt_act_pkg::ST_WAIT_SWITCH: begin
          if (cmd_actloop) begin
            nxt_loop = 1'b1;
          end
          if (cmd_switch || cmd_lswitch) begin
            nxt_state = nt_act_pkg::ST_ACTIVATED;
            nxt_loop  = cmd_lswitch || loop_ff;
          end else if (rx_not_i3) begin
            // Info 3 dropped before switch-through: wait for it again
            nxt_state = nt_act_pkg::ST_PEND_ACT;
          end
        end
        nt_act_pkg::ST_ACTIVATED: begin
          if (cmd_lswitch) begin
            nxt_loop = 1'b1;
          end
          if (cmd_nsync) begin
            nxt_state = nt_act_pkg::ST_LOST_UP;
          end else if (!rx_synced) begin
            nxt_state = nt_act_pkg::ST_LOST_LINE;
          end
        end
        nt_act_pkg::ST_LOST_LINE: begin
          if (cmd_nsync) begin
            nxt_state = nt_act_pkg::ST_LOST_UP;
          end else if (rx_synced && rx_i3) begin
            nxt_state = nt_act_pkg::ST_ACTIVATED;
          end
        end
        nt_act_pkg::ST_LOST_UP: begin
          if (cmd_switch || cmd_lswitch) begin
            nxt_state = nt_act_pkg::ST_ACTIVATED;
          end
        end
        nt_act_pkg::ST_PEND_DEACT: begin
          if (i0_done || tmo_done) begin
            nxt_state = nt_act_pkg::ST_WAIT_CONFIRM;
          end
        end
        nt_act_pkg::ST_WAIT_CONFIRM: begin
          if (cmd_confirm) begin
            nxt_state = nt_act_pkg::ST_DEACTIVATED;
          end
        end
        nt_act_pkg::ST_TEST_SINGLE, nt_act_pkg::ST_TEST_CONT: begin
          nxt_state = state_ff;
        end
        default: begin
          nxt_state = nt_act_pkg::ST_DEACTIVATED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= nt_act_pkg::ST_DEACTIVATED;
      loop_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      loop_ff  <= nxt_loop;
    end
  end

  // Outputs decoded from the next state so every port is a register
  logic [3:0] nxt_ind;
  logic [2:0] nxt_tx;
  always_comb begin
    nxt_ind = `IND_TIMING;
    nxt_tx  = `TX_INFO0;
    unique case (nxt_state)
      nt_act_pkg::ST_INFO0_SEEN:   nxt_ind = `IND_ACT_REQ;
      nt_act_pkg::ST_PEND_ACT:     nxt_tx  = `TX_INFO2;
      nt_act_pkg::ST_WAIT_SWITCH:  nxt_tx  = `TX_INFO2;
      nt_act_pkg::ST_ACTIVATED: begin
        nxt_tx  = `TX_INFO4;
        nxt_ind = `IND_ACT;
      end
      nt_act_pkg::ST_LOST_LINE: begin
        nxt_tx  = `TX_INFO2;
        nxt_ind = `IND_NOT_SYNC;
      end
      nt_act_pkg::ST_LOST_UP: begin
        nxt_tx  = `TX_INFO2;
        nxt_ind = `IND_NOT_SYNC;
      end
      nt_act_pkg::ST_PEND_DEACT:   nxt_ind = `IND_TIMING;
      nt_act_pkg::ST_WAIT_CONFIRM: nxt_ind = `IND_DEACT;
      nt_act_pkg::ST_TEST_SINGLE:  nxt_tx  = `TX_SINGLE_PULSE;
      nt_act_pkg::ST_TEST_CONT:    nxt_tx  = `TX_CONT_PULSE;
      default: begin
        nxt_ind = `IND_TIMING;
        nxt_tx  = `TX_INFO0;
      end
    endcase
    // Violation overrides only while enabled and activated
    if (violation_report_en && rx_cv && nxt_state == nt_act_pkg::ST_ACTIVATED) begin
      nxt_ind = `IND_CODE_VIOL;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      indication           <= `IND_TIMING;
      tx_info_sel          <= `TX_INFO0;
      loop2_closed         <= 1'b0;
      channels_transparent <= 1'b0;
      clock_stop           <= 1'b0;
      rx_ignore            <= 1'b0;
    end else begin
      indication           <= nxt_ind;
      tx_info_sel          <= nxt_tx;
      loop2_closed         <= nxt_loop;
      channels_transparent <= (nxt_state == nt_act_pkg::ST_ACTIVATED);
      clock_stop           <= clock_freeze_sel && (nxt_state == nt_act_pkg::ST_DEACTIVATED);
      rx_ignore            <= cmd_reset;
    end
  end

  // Checks
  sequence s_switch_seen;
    (state_ff == nt_act_pkg::ST_WAIT_SWITCH) && cmd_switch && !cmd_reset;
  endsequence

  sequence s_act_cmd_info0;
    (state_ff == nt_act_pkg::ST_INFO0_SEEN) && cmd_act;
  endsequence

  sequence s_nsync_activated;
    (state_ff == nt_act_pkg::ST_ACTIVATED) && cmd_nsync;
  endsequence

  AST_DEACT_TX: assert property (@(posedge clk) disable iff (reset)
    cmd_deact |=> (tx_info_sel == `TX_INFO0))
    else $error("deactivation request did not send info 0");
  AST_INFO0_REPORT: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_INFO0_SEEN) |-> (indication == `IND_ACT_REQ))
    else $error("info 0 seen without activation request indication");
  AST_PEND_INFO2: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_PEND_ACT) |-> (tx_info_sel == `TX_INFO2))
    else $error("pending activation not sending info 2");
  AST_SWITCH: assert property (@(posedge clk) disable iff (reset)
    s_switch_seen |=> (state_ff == nt_act_pkg::ST_ACTIVATED) && (tx_info_sel == `TX_INFO4) && channels_transparent)
    else $error("switch-through did not activate");
  AST_LOOP: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_ACTIVATED) && cmd_lswitch && !cmd_nsync |=> loop2_closed)
    else $error("loop 2 not closed");
  AST_LOST_SYNC: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_LOST_LINE) |-> (indication == `IND_NOT_SYNC))
    else $error("lost framing without not-synchronous indication");
  AST_RESET_CMD: assert property (@(posedge clk) disable iff (reset)
    cmd_reset |=> (state_ff == nt_act_pkg::ST_RESET_HOLD) && rx_ignore && (tx_info_sel == `TX_INFO0))
    else $error("reset command not obeyed");
  AST_DEACT_IND: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_PEND_DEACT) && tmo_done && !cmd_reset && !cmd_single && !cmd_cont
      |=> (indication == `IND_DEACT))
    else $error("deactivation indication missing after timeout");
  AST_CV_GATE: assert property (@(posedge clk) disable iff (reset)
    !$past(violation_report_en) |-> (indication != `IND_CODE_VIOL))
    else $error("violation reported while disabled");
  AST_CONFIRM: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_WAIT_CONFIRM) && cmd_confirm |=> (state_ff == nt_act_pkg::ST_DEACTIVATED))
    else $error("confirm did not return to deactivated");

  // Deactivation timer checks are only reached in runs beyond 3.2 million cycles
  AST_ACT_START: assert property (@(posedge clk) disable iff (reset)
    s_act_cmd_info0 |=> (state_ff == nt_act_pkg::ST_PEND_ACT) && (tx_info_sel == `TX_INFO2))
    else $error("activation command did not start info 2");
  AST_LOST_UP: assert property (@(posedge clk) disable iff (reset)
    s_nsync_activated |=> (state_ff == nt_act_pkg::ST_LOST_UP) && (tx_info_sel == `TX_INFO2))
    else $error("upstream lost framing not entered");
  AST_IDLE_SILENT: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_DEACTIVATED) |-> (tx_info_sel == `TX_INFO0))
    else $error("deactivated state is transmitting");
  AST_CLOCK_STOP: assert property (@(posedge clk) disable iff (reset)
    clock_stop |-> $past(clock_freeze_sel) && (state_ff == nt_act_pkg::ST_DEACTIVATED))
    else $error("clocks stopped outside deactivated or without freeze select");
  AST_INFO4_TRANSPARENT: assert property (@(posedge clk) disable iff (reset)
    (tx_info_sel == `TX_INFO4) |-> channels_transparent)
    else $error("info 4 sent without transparent channels");
  AST_TIMING_IND: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_PEND_DEACT) |-> (indication == `IND_TIMING))
    else $error("pending deactivation without timing indication");
  AST_WAIT_CONFIRM_IND: assert property (@(posedge clk) disable iff (reset)
    (state_ff == nt_act_pkg::ST_WAIT_CONFIRM) |-> (indication == `IND_DEACT))
    else $error("final deactivation state without deactivation indication");
  AST_TEST_ENTRY: assert property (@(posedge clk) disable iff (reset)
    !in_test && cmd_cont |=> (tx_info_sel == `TX_CONT_PULSE))
    else $error("continuous pulse test not entered");
  AST_IGNORE_LINE: assert property (@(posedge clk) disable iff (reset)
    rx_ignore |-> (state_ff == nt_act_pkg::ST_RESET_HOLD))
    else $error("line ignored outside reset hold");
endmodule : nt_line_activation_fsm
`default_nettype wire

// >>> hw/pin_sync.sv
// Three-stage synchroniser for one pin, with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign level_out = lvl_ff;
endmodule : pin_sync
`default_nettype wire

// >>> tb/nt_line_activation_fsm_tb_top.sv
// Self-checking testbench for the network-termination activation controller
`timescale 1ns/1ps
`default_nettype none
`include "nt_act_map.svh"
module nt_line_activation_fsm_tb_top;
  logic       clk;
  logic       reset;
  logic       clock_freeze_sel;
  logic       violation_report_en;
  logic [3:0] command_indicate_field;
  logic       rx_info0_pin;
  logic       rx_info3_pin;
  logic       rx_sync_pin;
  logic       rx_code_viol_pin;
  logic [3:0] indication;
  logic [2:0] tx_info_sel;
  logic       loop2_closed;
  logic       channels_transparent;
  logic       clock_stop;
  logic       rx_ignore;
  int         n_fail;
  int         checks_done;

  nt_line_activation_fsm u_dut (
    .clk                    (clk),
    .reset                  (reset),
    .clock_freeze_sel       (clock_freeze_sel),
    .violation_report_en    (violation_report_en),
    .command_indicate_field (command_indicate_field),
    .rx_info0_pin           (rx_info0_pin),
    .rx_info3_pin           (rx_info3_pin),
    .rx_sync_pin            (rx_sync_pin),
    .rx_code_viol_pin       (rx_code_viol_pin),
    .indication             (indication),
    .tx_info_sel            (tx_info_sel),
    .loop2_closed           (loop2_closed),
    .channels_transparent   (channels_transparent),
    .clock_stop             (clock_stop),
    .rx_ignore              (rx_ignore)
  );

  upstream_ctrl_model u_up (
    .clk                    (clk),
    .command_indicate_field (command_indicate_field)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check4(input string name, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check4

  task automatic check3(input string name, input logic [2:0] exp, input logic [2:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check3

  task automatic check1(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check1

  // Bounded waits cover the pin synchroniser latency
  task automatic wait_ind(input logic [3:0] exp);
    for (int i = 0; i < 12 && indication !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    check4("indication", exp, indication);
  endtask : wait_ind

  task automatic wait_tx(input logic [2:0] exp);
    for (int i = 0; i < 12 && tx_info_sel !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    check3("tx_info_sel", exp, tx_info_sel);
  endtask : wait_tx

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic t_reset_state();
    check4("indication", `IND_TIMING, indication);
    check3("tx_info_sel", `TX_INFO0, tx_info_sel);
    check1("clock_stop", 1'b1, clock_stop);
    clock_freeze_sel = 1'b0;
    settle(3);
    check1("clock_stop", 1'b0, clock_stop);
    $display("test reset_state done");
  endtask : t_reset_state

  task automatic t_terminal_act();
    rx_info0_pin = 1'b1;
    wait_ind(`IND_ACT_REQ);
    check3("tx_info_sel", `TX_INFO0, tx_info_sel);
    u_up.send_cmd(`CMD_ACT_REQ);
    wait_tx(`TX_INFO2);
    rx_info0_pin = 1'b0;
    rx_info3_pin = 1'b1;
    rx_sync_pin  = 1'b1;
    settle(8);
    check3("tx_info_sel", `TX_INFO2, tx_info_sel);
    check1("channels_transparent", 1'b0, channels_transparent);
    u_up.send_cmd(`CMD_SWITCH_THRU);
    wait_tx(`TX_INFO4);
    wait_ind(`IND_ACT);
    check1("channels_transparent", 1'b1, channels_transparent);
    $display("test terminal_act done");
  endtask : t_terminal_act

  task automatic t_loop_viol();
    u_up.send_cmd(`CMD_LOOP_SWITCH);
    settle(2);
    check1("loop2_closed", 1'b1, loop2_closed);
    rx_code_viol_pin = 1'b1;
    settle(8);
    check4("indication", `IND_ACT, indication);
    violation_report_en = 1'b1;
    wait_ind(`IND_CODE_VIOL);
    rx_code_viol_pin = 1'b0;
    wait_ind(`IND_ACT);
    $display("test loop_viol done");
  endtask : t_loop_viol

  task automatic t_lost_framing();
    rx_sync_pin = 1'b0;
    wait_ind(`IND_NOT_SYNC);
    rx_sync_pin = 1'b1;
    wait_ind(`IND_ACT);
    u_up.send_cmd(`CMD_NOT_SYNC);
    wait_tx(`TX_INFO2);
    $display("test lost_framing done");
  endtask : t_lost_framing

  task automatic t_deact();
    u_up.send_cmd(`CMD_DEACT_REQ);
    wait_tx(`TX_INFO0);
    check4("indication", `IND_TIMING, indication);
    check1("channels_transparent", 1'b0, channels_transparent);
    check1("loop2_closed", 1'b0, loop2_closed);
    rx_info3_pin = 1'b0;
    rx_sync_pin  = 1'b0;
    rx_info0_pin = 1'b1;
    // The full 16 ms hold is out of reach here; only an early report is caught
    settle(2000);
    check4("indication", `IND_TIMING, indication);
    $display("test deact done");
  endtask : t_deact

  task automatic t_reset_cmd();
    u_up.send_cmd(`CMD_STATE_RESET);
    settle(1);
    check1("rx_ignore", 1'b1, rx_ignore);
    check3("tx_info_sel", `TX_INFO0, tx_info_sel);
    settle(10);
    check4("indication", `IND_TIMING, indication);
    u_up.send_cmd(`CMD_DEACT_CONFIRM);
    wait_ind(`IND_ACT_REQ);
    check1("rx_ignore", 1'b0, rx_ignore);
    $display("test reset_cmd done");
  endtask : t_reset_cmd

  task automatic t_loop_act();
    rx_info0_pin = 1'b0;
    u_up.send_cmd(`CMD_ACT_LOOP);
    wait_tx(`TX_INFO2);
    check1("loop2_closed", 1'b1, loop2_closed);
    $display("test loop_act done");
  endtask : t_loop_act

  task automatic t_test_modes();
    u_up.send_cmd(`CMD_SINGLE_PULSE);
    wait_tx(`TX_SINGLE_PULSE);
    u_up.send_cmd(`CMD_CONT_PULSE);
    wait_tx(`TX_CONT_PULSE);
    u_up.send_cmd(`CMD_DEACT_REQ);
    wait_tx(`TX_INFO0);
    $display("test test_modes done");
  endtask : t_test_modes

  initial begin
    n_fail              = 0;
    checks_done         = 0;
    reset               = 1'b1;
    clock_freeze_sel    = 1'b1;
    violation_report_en = 1'b0;
    rx_info0_pin        = 1'b0;
    rx_info3_pin        = 1'b0;
    rx_sync_pin         = 1'b0;
    rx_code_viol_pin    = 1'b0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    settle(1);
    t_reset_state();
    t_terminal_act();
    t_loop_viol();
    t_lost_framing();
    t_deact();
    t_reset_cmd();
    t_loop_act();
    t_test_modes();
    final_report();
  end

  // Whole run takes about 2100 cycles; this bound allows 20000
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : nt_line_activation_fsm_tb_top
`default_nettype wire

// >>> tb/upstream_ctrl_model.sv
// Upstream controller model that drives the command field of the activation controller
`timescale 1ns/1ps
`default_nettype none
`include "nt_act_map.svh"
module upstream_ctrl_model (
  // Clock
  input  wire logic       clk,
  // Command field
  output var  logic [3:0] command_indicate_field
);
  logic last_was_test;

  initial begin
    command_indicate_field = `CMD_DEACT_CONFIRM;
    last_was_test          = 1'b0;
  end

  // A code stays on the field after the call; a real upstream never leaves it blank
  task automatic send_cmd(input logic [3:0] code);
    logic is_test;
    is_test = (code == `CMD_SINGLE_PULSE) || (code == `CMD_CONT_PULSE);
    // Swapping test codes needs a deactivation request in between
    if (is_test && last_was_test && code != command_indicate_field) begin
      @(posedge clk);
      #1 command_indicate_field = `CMD_DEACT_REQ;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    #1 command_indicate_field = code;
    repeat (2) @(posedge clk);
    #1;
    last_was_test = is_test;
  endtask : send_cmd
endmodule : upstream_ctrl_model
`default_nettype wire
